/* File: core/evt_timer.sv */
// Event timer: clock select, clear sources, flags, interrupt and waveform output
// Operation
// - Control zero bit 7 lets a set compare B flag request an interrupt.
// - Control zero bit 6 lets a set compare A flag request an interrupt.
// - Control zero bit 5 lets a set overflow flag request an interrupt.
// - Clear field bits 4:3: none, match A, match B, clear pin rising edge.
// - Trigger enable decides whether counting halts after a clear.
// - Clock field bits 2:0 plus extension bit pick clock; 000, 100 stop.
// - Codes 001..011 count prescaled clocks /4,/8 up to /64,/128.
// - Codes 101..111 count pin rising, falling, both edges; extension ignored.
// - Compare B flag, status bit 7, sets on match; cleared by write 0 after read 1.
// - Compare A flag, status bit 6, sets on match; cleared by write 0 after read 1.
// - Overflow flag, status bit 5, sets on wrap FF to 00; same clearing.
// - Status bit 4 always reads as 1.
// - Match B drives the output per bits 3:2: hold, 0, 1, toggle.
// - Match A drives the output per bits 1:0: hold, 0, 1, toggle.
// - Actions for match A and match B are set independently.
// - Output is 0 after reset until the first compare match.
// - Counter resets to zero, both constants reset to all ones.
// - With trigger enable, counting halts on clear, resumes on trigger edge.
// - Match fires in the last state where counter equals constant.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module evt_timer #(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              external_count_clock_pin,
  input  wire logic              external_clear_pin,
  input  wire logic              trigger_pin,
  output logic                   waveform_out,
  output logic                   timer_irq
);
  // Refuse an address bus too narrow for the register map
  if (ADDR_W < 8) begin : g_bad_addr
    $error("evt_timer: ADDR_W must be at least 8");
  end

  // Registers and state
  logic [7:0] timer_control_zero;
  logic [1:0] trig_edge_sel;
  logic       trigger_start_enable;
  logic       clock_select_extension;
  logic [3:0] action_sel;
  logic [2:0] flags;
  logic [2:0] armed;
  logic [7:0] event_counter;
  logic [7:0] constant_a;
  logic [7:0] constant_b;
  logic       started;
  logic       ext_clk_prev;
  logic       clr_pin_prev;
  logic       trig_prev;

  // APB decode: answer one cycle into the access phase
  wire        acc_first  = psel & penable & ~pready;
  wire        acc_done   = psel & penable & pready;
  wire [7:0]  addr_lo    = paddr[7:0];
  wire        hi_zero    = (paddr >> 8) == '0;
  wire        sel_ctl0   = hi_zero & (addr_lo == evt_pkg::OFF_CTL0);
  wire        sel_ctl1   = hi_zero & (addr_lo == evt_pkg::OFF_CTL1);
  wire        sel_stat   = hi_zero & (addr_lo == evt_pkg::OFF_STAT);
  wire        sel_cnt    = hi_zero & (addr_lo == evt_pkg::OFF_CNT);
  wire        sel_cona   = hi_zero & (addr_lo == evt_pkg::OFF_CONA);
  wire        sel_conb   = hi_zero & (addr_lo == evt_pkg::OFF_CONB);
  wire        mapped     = sel_ctl0 | sel_ctl1 | sel_stat | sel_cnt | sel_cona | sel_conb;
  wire        wr_en      = acc_done & pwrite;
  wire        wr_ctl0    = wr_en & sel_ctl0;
  wire        wr_ctl1    = wr_en & sel_ctl1;
  wire        wr_stat    = wr_en & sel_stat;
  wire        wr_cnt     = wr_en & sel_cnt;
  wire        wr_cona    = wr_en & sel_cona;
  wire        wr_conb    = wr_en & sel_conb;
  wire        rd_stat    = acc_done & ~pwrite & sel_stat;
  wire [7:0]  wbyte      = pwdata[7:0];

  // Read views; reserved bits read as 1
  wire [7:0]  ctl1_view  = evt_pkg::CTL1_RSVD
                         | ({6'h00, trig_edge_sel} << evt_pkg::TEDGE_LSB)
                         | ({7'h00, trigger_start_enable} << evt_pkg::TRIGGER_START_ENABLE_BIT)
                         | ({7'h00, clock_select_extension} << evt_pkg::EXT_BIT);
  wire [7:0]  stat_view  = ({5'h00, flags} << evt_pkg::FLAG_LSB)
                         | evt_pkg::STAT_RSVD
                         | {4'h0, action_sel};
  wire [7:0]  rd_byte    = sel_ctl0 ? timer_control_zero :
                           sel_ctl1 ? ctl1_view :
                           sel_stat ? stat_view :
                           sel_cnt  ? event_counter :
                           sel_cona ? constant_a :
                           sel_conb ? constant_b : 8'h00;

  // Field views of control register zero and the status action bits
  wire [2:0]  irq_en     = timer_control_zero[evt_pkg::IEN_LSB +: 3];
  wire [1:0]  clr_sel    = timer_control_zero[evt_pkg::CCLR_LSB +: 2];
  wire [2:0]  clk_sel    = timer_control_zero[evt_pkg::CKS_LSB +: 3];
  wire [1:0]  act_b      = action_sel[evt_pkg::ACTB_LSB +: 2];
  wire [1:0]  act_a      = action_sel[evt_pkg::ACTA_LSB +: 2];

  // Internal prescaled clocks
  logic [evt_pkg::N_TAP-1:0] div_tick;
  evt_prescaler #(
    .DIV_W (evt_pkg::DIV_W),
    .N_TAP (evt_pkg::N_TAP)
  ) u_prescaler (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .div_tick (div_tick)
  );

  // Count clock selection
  wire [2:0]  tap_idx    = {clk_sel[1:0] - 2'h1, clock_select_extension};
  wire        int_tick   = (clk_sel[1:0] != 2'h0) & div_tick[tap_idx];
  wire        ext_rise   = external_count_clock_pin & ~ext_clk_prev;
  wire        ext_fall   = ~external_count_clock_pin & ext_clk_prev;
  wire        ext_tick   = ((clk_sel[1:0] == evt_pkg::EDGE_RISE) & ext_rise)
                         | ((clk_sel[1:0] == evt_pkg::EDGE_FALL) & ext_fall)
                         | ((clk_sel[1:0] == evt_pkg::EDGE_BOTH) & (ext_rise | ext_fall));
  wire        src_tick   = clk_sel[2] ? ext_tick : int_tick;

  // Trigger gating of the count
  wire        trig_rise  = trigger_pin & ~trig_prev;
  wire        trig_fall  = ~trigger_pin & trig_prev;
  wire        trig_edge  = ((trig_edge_sel == evt_pkg::EDGE_RISE) & trig_rise)
                         | ((trig_edge_sel == evt_pkg::EDGE_FALL) & trig_fall)
                         | ((trig_edge_sel == evt_pkg::EDGE_BOTH) & (trig_rise | trig_fall));
  wire        running    = ~trigger_start_enable | started;
  wire        tick       = src_tick & running;

  // Matches fire on the count that leaves the equal value; a constant write masks it
  wire        match_a    = tick & (event_counter == constant_a) & ~wr_cona;
  wire        match_b    = tick & (event_counter == constant_b) & ~wr_conb;
  wire        wrap       = tick & (event_counter == evt_pkg::CNT_TOP);

  // Clear source selection
  wire        clr_rise   = external_clear_pin & ~clr_pin_prev;
  wire        clear_evt  = ((clr_sel == evt_pkg::CCLR_A) & match_a)
                         | ((clr_sel == evt_pkg::CCLR_B) & match_b)
                         | ((clr_sel == evt_pkg::CCLR_PIN) & clr_rise);

  // Counter next value: clear beats write, write beats count
  wire [7:0]  next_counter = clear_evt ? evt_pkg::CNT_RST :
                             wr_cnt    ? wbyte :
                             tick      ? event_counter + 8'h01 : event_counter;

  // Trigger run state: clear halts, selected edge restarts
  wire        next_started = (trigger_start_enable & clear_evt) ? 1'b0 :
                             trig_edge ? 1'b1 : started;

  // Flags in status order: overflow, match A, match B
  wire [2:0]  flag_set   = {match_b, match_a, wrap};
  wire [2:0]  wr_flags   = wbyte[evt_pkg::FLAG_LSB +: 3];
  logic [2:0] next_flags;
  logic [2:0] next_armed;
  for (genvar i = 0; i < 3; i++) begin : g_flag
    // Set wins over a clear in the same cycle
    assign next_flags[i] = flag_set[i]
                         | (flags[i] & ~(wr_stat & ~wr_flags[i] & armed[i]));
    assign next_armed[i] = wr_stat ? 1'b0 : (armed[i] | (rd_stat & flags[i]));
  end

  // Interrupt request from enabled flags
  wire        next_irq   = |(next_flags & irq_en);

  // Waveform action; match B applied last so it wins a conflict
  function automatic logic apply_act(input logic [1:0] act, input logic lvl);
    unique case (act)
      evt_pkg::ACT_HOLD: apply_act = lvl;
      evt_pkg::ACT_LOW:  apply_act = 1'b0;
      evt_pkg::ACT_HIGH: apply_act = 1'b1;
      evt_pkg::ACT_TOG:  apply_act = ~lvl;
    endcase
  endfunction
  wire        wave_a     = match_a ? apply_act(act_a, waveform_out) : waveform_out;
  wire        wave_b     = match_b ? apply_act(act_b, waveform_out) : waveform_out;
  wire        b_active   = match_b & (act_b != evt_pkg::ACT_HOLD);
  wire        next_wave  = b_active ? wave_b : wave_a;

  // APB answer registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~mapped;
      prdata  <= acc_first & ~pwrite ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_control_zero     <= 8'h00;
      trig_edge_sel          <= evt_pkg::EDGE_NONE;
      trigger_start_enable   <= 1'b0;
      clock_select_extension <= 1'b0;
      action_sel             <= 4'h0;
    end else begin
      if (wr_ctl0) begin
        timer_control_zero <= wbyte;
      end
      if (wr_ctl1) begin
        trig_edge_sel          <= wbyte[evt_pkg::TEDGE_LSB +: 2];
        trigger_start_enable   <= wbyte[evt_pkg::TRIGGER_START_ENABLE_BIT];
        clock_select_extension <= wbyte[evt_pkg::EXT_BIT];
      end
      if (wr_stat) begin
        action_sel <= wbyte[3:0];
      end
    end
  end

  // Constants, counter and run state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      constant_a    <= evt_pkg::CONST_RST;
      constant_b    <= evt_pkg::CONST_RST;
      event_counter <= evt_pkg::CNT_RST;
      started       <= 1'b0;
    end else begin
      if (wr_cona) begin
        constant_a <= wbyte;
      end
      if (wr_conb) begin
        constant_b <= wbyte;
      end
      event_counter <= next_counter;
      started       <= next_started;
    end
  end

  // Flags, interrupt, waveform and pin history
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags        <= 3'h0;
      armed        <= 3'h0;
      timer_irq    <= 1'b0;
      waveform_out <= 1'b0;
      ext_clk_prev <= 1'b0;
      clr_pin_prev <= 1'b0;
      trig_prev    <= 1'b0;
    end else begin
      flags        <= next_flags;
      armed        <= next_armed;
      timer_irq    <= next_irq;
      waveform_out <= next_wave;
      ext_clk_prev <= external_count_clock_pin;
      clr_pin_prev <= external_clear_pin;
      trig_prev    <= trigger_pin;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_irq_b_gate: assert property (flags[2] && $past(irq_en[2]) |-> timer_irq)
    else $error("compare B interrupt not raised");
  chk_irq_a_gate: assert property (flags[1] && $past(irq_en[1]) |-> timer_irq)
    else $error("compare A interrupt not raised");
  chk_irq_wrap_gate: assert property (flags[0] && $past(irq_en[0]) |-> timer_irq)
    else $error("overflow interrupt not raised");
  chk_irq_quiet: assert property (
    $past(!(|(next_flags & irq_en))) |-> !timer_irq)
    else $error("interrupt without enabled flag");
  chk_clear_match_a: assert property (
    clr_sel == evt_pkg::CCLR_A && match_a |=> event_counter == 8'h00)
    else $error("counter not cleared by match A");
  chk_clear_pin: assert property (
    clr_sel == evt_pkg::CCLR_PIN && clr_rise |=> event_counter == 8'h00)
    else $error("counter not cleared by clear pin");
  chk_clock_stop: assert property (
    clk_sel[1:0] == 2'h0 && !wr_cnt && !clear_evt |=> $stable(event_counter))
    else $error("counter moved with clock stopped");
  chk_div4_tick: assert property (
    clk_sel == 3'h1 && !clock_select_extension && src_tick |-> div_tick[0])
    else $error("divide by 4 tick out of step");
  chk_ext_rise: assert property (
    clk_sel == 3'h5 && running && ext_rise && !wr_cnt && !clear_evt
    |=> event_counter == $past(event_counter) + 8'h01)
    else $error("external rising edge not counted");
  chk_flag_hold: assert property (flags[2] && !wr_stat |=> flags[2])
    else $error("compare B flag lost");
  chk_flag_noarm: assert property (flags[1] && !armed[1] |=> flags[1])
    else $error("compare A flag cleared without read");
  chk_wrap_set: assert property (wrap && !wr_cnt |=> flags[0] && event_counter == 8'h00)
    else $error("overflow flag not set");
  chk_rsvd_one: assert property (acc_first && !pwrite && sel_stat |=> prdata[4])
    else $error("reserved status bit read as 0");
  chk_wave_start: assert property ($rose(waveform_out) |-> $past(match_a || match_b))
    else $error("waveform changed without match");
  chk_trig_halt: assert property (
    trigger_start_enable && clear_evt |=> !started ##1 !started || $past(trig_edge))
    else $error("count not halted after clear");
  chk_wave_b_wins: assert property (
    match_a && match_b && act_b == evt_pkg::ACT_LOW && act_a == evt_pkg::ACT_HIGH
    |=> !waveform_out)
    else $error("match B action not applied");
endmodule

/* File: shared/evt_pkg.sv */
// Constants shared by the event timer: register map, field layout, codes, reset values
package evt_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFF_CTL0  = 8'h00;
  localparam logic [7:0] OFF_CTL1  = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_CNT   = 8'h0C;
  localparam logic [7:0] OFF_CONA  = 8'h10;
  localparam logic [7:0] OFF_CONB  = 8'h14;

  // Control register zero fields
  localparam int IEN_LSB   = 5;
  localparam int CCLR_LSB  = 3;
  localparam int CKS_LSB   = 0;
  // Control register one fields
  localparam int TEDGE_LSB = 3;
  localparam int TRIGGER_START_ENABLE_BIT  = 2;
  localparam int EXT_BIT   = 0;
  localparam logic [7:0] CTL1_RSVD = 8'hE2;
  // Status and output register fields
  localparam int FLAG_LSB  = 5;
  localparam int ACTB_LSB  = 2;
  localparam int ACTA_LSB  = 0;
  localparam logic [7:0] STAT_RSVD = 8'h10;

  // Reset values and the counter top value
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CONST_RST = 8'hFF;
  localparam logic [7:0] CNT_TOP   = 8'hFF;

  // Clear source codes
  localparam logic [1:0] CCLR_NONE = 2'h0;
  localparam logic [1:0] CCLR_A    = 2'h1;
  localparam logic [1:0] CCLR_B    = 2'h2;
  localparam logic [1:0] CCLR_PIN  = 2'h3;

  // Waveform action codes
  localparam logic [1:0] ACT_HOLD  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_HIGH  = 2'h2;
  localparam logic [1:0] ACT_TOG   = 2'h3;

  // Edge select codes for the trigger pin and external clock
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Prescaler: six taps, divide by 4 up to 128
  localparam int DIV_W     = 7;
  localparam int N_TAP     = 6;
endpackage

/* File: core/evt_prescaler.sv */
// Free running prescaler giving one-cycle enables at divide by 4 up to 128
`timescale 1ns/1ps
module evt_prescaler #(
  parameter int DIV_W = 7,
  parameter int N_TAP = 6
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  output wire logic [N_TAP-1:0] div_tick
);
  // Refuse a counter too short for the highest tap
  if (DIV_W < N_TAP + 1) begin : g_bad_width
    $error("evt_prescaler: DIV_W too small for N_TAP");
  end

  logic [DIV_W-1:0] pre_cnt;

  // Divider counter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_cnt <= {DIV_W{1'b0}};
    end else begin
      pre_cnt <= pre_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // Tap i pulses just before bit i+1 falls, once every 2**(i+2) cycles
  for (genvar i = 0; i < N_TAP; i++) begin : g_tap
    assign div_tick[i] = &pre_cnt[i+1:0];
  end
endmodule

/* File: verif/evt_pins_model.sv */
// Pin-side model: drives the external clock, clear and trigger pins
`timescale 1ns/1ps
module evt_pins_model (
  input  wire logic ref_clk,
  output logic      ext_clk,
  output logic      clr_pin,
  output logic      trig_pin
);
  logic [2:0] lvl;

  // Pins idle low between pulses
  assign ext_clk  = lvl[0];
  assign clr_pin  = lvl[1];
  assign trig_pin = lvl[2];

  initial lvl = 3'h0;

  // High two cycles, low two cycles, so the sampler sees both edges
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      lvl[sel] <= 1'h1;
      repeat (2) @(posedge ref_clk);
      lvl[sel] <= 1'h0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the event timer over APB and its pins
`timescale 1ns/1ps
module testbench;
  logic        ref_clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_clk;
  logic        clr_pin;
  logic        trig_pin;
  logic        waveform_out;
  logic        timer_irq;
  logic        last_err;
  logic [7:0]  r;
  int          fails;
  int          tests_run;
  int          cyc;
  int          dv;

  evt_timer #(.ADDR_W(8)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .external_count_clock_pin(ext_clk),
    .external_clear_pin(clr_pin), .trigger_pin(trig_pin),
    .waveform_out(waveform_out), .timer_irq(timer_irq)
  );

  evt_pins_model u_pins (
    .ref_clk(ref_clk), .ext_clk(ext_clk), .clr_pin(clr_pin), .trig_pin(trig_pin)
  );

  // 25 MHz clock
  initial ref_clk = 1'h0;
  always #20 ref_clk = ~ref_clk;

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("ERROR %0t: timeout", $time);
      end_of_test();
    end
  end

  // One APB transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    r        = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: pin %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk_rng(input logic [7:0] g, input int l, input int h);
    tests_run++;
    if ($isunknown(g) || g < l || g > h) begin
      fails++;
      $display("ERROR %0t: count %h outside %0d..%0d", $time, g, l, h);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk8(r, e);
  endtask

  task automatic done(input string s);
    $display("Test done: %s", s);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    srst    = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    // Reset values, reserved bits and an unmapped address
    rd_chk(evt_pkg::OFF_CTL0, 8'h00);
    rd_chk(evt_pkg::OFF_CTL1, evt_pkg::CTL1_RSVD);
    rd_chk(evt_pkg::OFF_STAT, 8'h10);
    rd_chk(evt_pkg::OFF_CNT, 8'h00);
    rd_chk(evt_pkg::OFF_CONA, 8'hFF);
    rd_chk(evt_pkg::OFF_CONB, 8'hFF);
    chk1(waveform_out, 1'h0);
    chk1(timer_irq, 1'h0);
    rd_chk(8'h18, 8'h00);
    chk1(last_err, 1'h1);
    done("reset and map");
    // Internal prescaled clocks; codes 000 and 100 stay still
    for (int c = 0; c < 5; c++) begin
      for (int e = 0; e < 2; e++) begin
        dv = (c % 4 == 0) ? 64 : 4 << (2 * c - 2 + e);
        wr(evt_pkg::OFF_CNT, 8'h00);
        wr(evt_pkg::OFF_CTL1, 8'(e));
        wr(evt_pkg::OFF_CTL0, 8'(c));
        repeat (4 * dv) @(posedge ref_clk);
        wr(evt_pkg::OFF_CTL0, 8'h00);
        apb(1'h0, evt_pkg::OFF_CNT, 8'h00);
        chk_rng(r, (c % 4 == 0) ? 0 : 4, (c % 4 == 0) ? 0 : 5);
      end
    end
    done("internal clocks");
    // Pin edges: rising, falling, both; extension bit set and ignored
    for (int c = 5; c < 8; c++) begin
      wr(evt_pkg::OFF_CNT, 8'h00);
      wr(evt_pkg::OFF_CTL1, 8'h01);
      wr(evt_pkg::OFF_CTL0, 8'(c));
      u_pins.pulse(0, 3);
      wr(evt_pkg::OFF_CTL0, 8'h00);
      rd_chk(evt_pkg::OFF_CNT, (c == 7) ? 8'h06 : 8'h03);
    end
    wr(evt_pkg::OFF_CTL1, 8'h00);
    done("pin clocks");
    // Clear sources: none, match A at 2, match B at 3, then the clear pin
    wr(evt_pkg::OFF_CONA, 8'h02);
    wr(evt_pkg::OFF_CONB, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(evt_pkg::OFF_CNT, 8'h00);
      wr(evt_pkg::OFF_CTL0, 8'h05 | 8'(i << 3));
      u_pins.pulse(0, 4);
      wr(evt_pkg::OFF_CTL0, 8'h00);
      rd_chk(evt_pkg::OFF_CNT, (i == 0) ? 8'h04 : (i == 1) ? 8'h01 : 8'h00);
    end
    wr(evt_pkg::OFF_CNT, 8'h00);
    wr(evt_pkg::OFF_CTL0, 8'h1D);
    u_pins.pulse(0, 3);
    rd_chk(evt_pkg::OFF_CNT, 8'h03);
    u_pins.pulse(1, 1);
    rd_chk(evt_pkg::OFF_CNT, 8'h00);
    done("clear sources");
    // Trigger enable: a clear halts, a rising trigger edge restarts
    wr(evt_pkg::OFF_CTL1, 8'h0C);
    rd_chk(evt_pkg::OFF_CTL1, 8'hEE);
    wr(evt_pkg::OFF_CTL0, 8'h0D);
    u_pins.pulse(0, 4);
    rd_chk(evt_pkg::OFF_CNT, 8'h00);
    u_pins.pulse(2, 1);
    u_pins.pulse(0, 1);
    rd_chk(evt_pkg::OFF_CNT, 8'h01);
    // Match A at 2 clears the counter, which then stays halted
    u_pins.pulse(0, 3);
    rd_chk(evt_pkg::OFF_CNT, 8'h00);
    wr(evt_pkg::OFF_CTL1, 8'h00);
    done("trigger");
    // Sticky flags clear only by read-one then write-zero
    rd_chk(evt_pkg::OFF_STAT, 8'hD0);
    wr(evt_pkg::OFF_STAT, 8'h00);
    rd_chk(evt_pkg::OFF_STAT, 8'h10);
    wr(evt_pkg::OFF_CONA, 8'h03);
    wr(evt_pkg::OFF_CONB, 8'hFF);
    wr(evt_pkg::OFF_STAT, 8'h03);
    wr(evt_pkg::OFF_CNT, 8'h00);
    wr(evt_pkg::OFF_CTL0, 8'h45);
    u_pins.pulse(0, 4);
    chk1(waveform_out, 1'h1);
    chk1(timer_irq, 1'h1);
    wr(evt_pkg::OFF_STAT, 8'h03);
    rd_chk(evt_pkg::OFF_STAT, 8'h53);
    wr(evt_pkg::OFF_STAT, 8'h03);
    rd_chk(evt_pkg::OFF_STAT, 8'h13);
    chk1(timer_irq, 1'h0);
    done("flag A and toggle");
    // Both matches at once, A drives high, B drives low: B wins
    wr(evt_pkg::OFF_CNT, 8'h00);
    wr(evt_pkg::OFF_CONA, 8'h02);
    wr(evt_pkg::OFF_CONB, 8'h02);
    wr(evt_pkg::OFF_STAT, 8'h06);
    wr(evt_pkg::OFF_CTL0, 8'h85);
    u_pins.pulse(0, 3);
    chk1(waveform_out, 1'h0);
    chk1(timer_irq, 1'h1);
    rd_chk(evt_pkg::OFF_STAT, 8'hD6);
    wr(evt_pkg::OFF_CTL0, 8'h05);
    repeat (2) @(posedge ref_clk);
    chk1(timer_irq, 1'h0);
    done("simultaneous match");
    // Wrap from FF to 00 sets the overflow flag and its request
    wr(evt_pkg::OFF_CNT, 8'hFE);
    wr(evt_pkg::OFF_CTL0, 8'h25);
    u_pins.pulse(0, 2);
    chk1(timer_irq, 1'h1);
    rd_chk(evt_pkg::OFF_STAT, 8'hF6);
    rd_chk(evt_pkg::OFF_CNT, 8'h00);
    done("overflow");
    end_of_test();
  end
endmodule
